// [rtl/eisb_map.svh]
// Constants of the two-wire slave bit layer: bus codes, counts and timing.
// Assumes inclusion by the package only; the main slave module uses the macros it defines.
`ifndef EISB_MAP_SVH
`define EISB_MAP_SVH

// ---------------------------------------------------------------
// Control byte decoding
// ---------------------------------------------------------------
`define EISB_PREFIX_TOP     3'h5
`define EISB_PREFIX_SPACE  4
`define EISB_DIR_BIT       0
`define EISB_SEL_VARIANT0  3'h0
`define EISB_SEL_VARIANT7  3'h7

// ---------------------------------------------------------------
// Byte framing
// ---------------------------------------------------------------
`define EISB_BYTE_BITS     4'h8
`define EISB_SLOT_END      4'h9
`define EISB_IDLE_BYTE     8'hff

// ---------------------------------------------------------------
// Buffering and timing
// ---------------------------------------------------------------
`define EISB_FIFO_DEPTH    4
`define EISB_CLK_PERIOD_NS 100
`define EISB_MIN_HALF_NS   500
`define EISB_MIN_HALF_CYC  (`EISB_MIN_HALF_NS / `EISB_CLK_PERIOD_NS)
`define EISB_SYNC_LAT_CYC  3

`endif

// [rtl/eisb_pkg.sv]
// Types shared by the two-wire slave bit layer.
// Assumes the constants header sits beside it.
package eisb_pkg;
`include "eisb_map.svh"

   // ---------------------------------------------------------------
   // Slave states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      EISB_IDLE   = 3'b000,
      EISB_CTRL   = 3'b001,
      EISB_WRITE  = 3'b010,
      EISB_READ   = 3'b011,
      EISB_IGNORE = 3'b100
   } eisb_state_t;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       first;
      logic [7:0] data;
   } eisb_rx_t;

   typedef struct packed {
      logic busy;
      logic selected;
      logic readMode;
      logic regSpace;
   } eisb_status_t;

endpackage

// [rtl/eisb_sync.sv]
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes idle level high, as for pulled-up bus lines.
`timescale 1ns/1ps
module eisb_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Levels
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] meta;

   // First stage is read by the second stage only
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta   <= '1;
         synced <= '1;
      end
      else
      begin
         meta   <= async;
         synced <= meta;
      end
   end

endmodule

// [rtl/eisb_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
module eisb_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr;
   logic [AW:0]      rdPtr;

   assign inReady  = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outValid = (wrPtr != rdPtr);
   assign outData  = mem[rdPtr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (inValid && inReady)
      begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
      end
      else
      begin
         if (inValid && inReady)
         begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (outValid && outReady)
         begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

endmodule

// [rtl/eisb_slave.sv]
// Bit layer of a two-wire serial memory slave: framing, select and ack.
// Assumes an external master making clock, START and STOP; lines pulled up.
`timescale 1ns/1ps
module eisb_slave
   import eisb_pkg::*;
#(
   parameter logic [2:0] SEL_VALUE = `EISB_SEL_VARIANT0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Bus pins
   input  wire logic         sclIn,
   input  wire logic         sdaIn,
   output logic              sdaOut,
   output logic              sdaOeN,
   // Received bytes
   output logic              rxValid,
   input  wire logic         rxReady,
   output eisb_rx_t          rxData,
   // Bytes to send
   input  wire logic         txValid,
   input  wire logic [7:0]   txData,
   output logic              txTaken,
   // Status
   output eisb_status_t      status,
   output logic              startPulse,
   output logic              stopPulse
);

   // ---------------------------------------------------------------
   // Sampling and condition detection
   // ---------------------------------------------------------------
   logic        sclS;
   logic        sdaS;
   logic        sclD;
   logic        sdaD;
   logic        sclRise;
   logic        sclFall;
   logic        startEv;
   logic        stopEv;
   eisb_state_t state;
   logic [3:0]  bitCnt;
   logic [7:0]  rxShift;
   logic [7:0]  txShift;
   logic [7:0]  nextTx;
   logic        driveLow;
   logic        txGo;
   logic        firstByte;
   logic        active;
   logic        ctrlMatch;
   logic        ackSlotFall;
   logic        slotEndFall;
   logic        pushReq;
   logic        pushReady;
   eisb_rx_t    pushData;

   function automatic logic decode_ctrl(input logic [7:0] ctrl, input logic [2:0] sel);
      decode_ctrl = (ctrl[7:5] == `EISB_PREFIX_TOP) && (ctrl[3:1] == sel);
   endfunction

   // Clock pin is only sampled; at 1 Mbit/s a half period is
   // EISB_MIN_HALF_CYC cycles, longer than the sampling latency.
   eisb_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .async  ({sclIn, sdaIn}),
      .synced ({sclS, sdaS})
   );

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         sclD <= 1'b1;
         sdaD <= 1'b1;
      end
      else
      begin
         sclD <= sclS;
         sdaD <= sdaS;
      end
   end

   assign sclRise = sclS && !sclD;
   assign sclFall = !sclS && sclD;
   assign startEv = sclS && sclD && sdaD && !sdaS;
   assign stopEv  = sclS && sclD && !sdaD && sdaS;
   assign active  = (state == EISB_CTRL) || (state == EISB_WRITE) || (state == EISB_READ);
   assign ctrlMatch   = decode_ctrl(rxShift, SEL_VALUE);
   assign ackSlotFall = sclFall && (bitCnt == `EISB_BYTE_BITS);
   assign slotEndFall = sclFall && (bitCnt == `EISB_SLOT_END);
   assign nextTx      = txValid ? txData : `EISB_IDLE_BYTE;

   // ---------------------------------------------------------------
   // Bit counting and shifting
   // ---------------------------------------------------------------
   // Counter restarts at every byte, so transfers have no length limit
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         bitCnt <= '0;
      end
      else if (startEv || stopEv)
      begin
         bitCnt <= '0;
      end
      else if (active && sclRise && (bitCnt <= `EISB_BYTE_BITS))
      begin
         bitCnt <= bitCnt + 4'h1;
      end
      else if (slotEndFall)
      begin
         bitCnt <= '0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rxShift <= '0;
      end
      else if (active && sclRise && (bitCnt < `EISB_BYTE_BITS))
      begin
         rxShift <= {rxShift[6:0], sdaS};
      end
   end

   // ---------------------------------------------------------------
   // Transfer state
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= EISB_IDLE;
      end
      else if (startEv)
      begin
         state <= EISB_CTRL;
      end
      else if (stopEv)
      begin
         state <= EISB_IDLE;
      end
      else if (ackSlotFall && (state == EISB_CTRL))
      begin
         case (ctrlMatch)
            1'b1:    state <= rxShift[`EISB_DIR_BIT] ? EISB_READ : EISB_WRITE;
            default: state <= EISB_IGNORE;
         endcase
      end
      else if (slotEndFall && (state == EISB_READ) && !txGo)
      begin
         state <= EISB_IGNORE;
      end
   end

   // Master acknowledge after each read byte decides whether to go on
   always_ff @(posedge clk)
   begin
      if (!rst_n || startEv || stopEv)
      begin
         txGo <= 1'b0;
      end
      else if (ackSlotFall && (state == EISB_CTRL))
      begin
         txGo <= ctrlMatch && rxShift[`EISB_DIR_BIT];
      end
      else if ((state == EISB_READ) && sclRise && (bitCnt == `EISB_BYTE_BITS))
      begin
         txGo <= !sdaS;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         txShift <= `EISB_IDLE_BYTE;
      end
      else if (slotEndFall && (state == EISB_READ) && txGo)
      begin
         txShift <= nextTx;
      end
      else if (sclFall && (state == EISB_READ) && (bitCnt != 4'h0) && (bitCnt < `EISB_BYTE_BITS))
      begin
         txShift <= {txShift[6:0], 1'b1};
      end
   end

   assign txTaken = slotEndFall && (state == EISB_READ) && txGo && txValid;

   // ---------------------------------------------------------------
   // Data line drive
   // ---------------------------------------------------------------
   // Written on clock falls only, so the line moves while clock is low.
   // A full receive buffer turns the byte's ack into a nack.
   always_ff @(posedge clk)
   begin
      if (!rst_n || startEv || stopEv || !active)
      begin
         driveLow <= 1'b0;
      end
      else if (ackSlotFall)
      begin
         driveLow <= ((state == EISB_CTRL) && ctrlMatch) || (pushReq && pushReady);
      end
      else if (slotEndFall)
      begin
         driveLow <= (state == EISB_READ) && txGo && !nextTx[7];
      end
      else if (sclFall && (state == EISB_READ) && (bitCnt != 4'h0))
      begin
         driveLow <= !txShift[6];
      end
      else if (sclFall)
      begin
         driveLow <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      sdaOut <= 1'b0;
   end

   assign sdaOeN = !driveLow;

   // ---------------------------------------------------------------
   // Receive buffer
   // ---------------------------------------------------------------
   assign pushReq  = ackSlotFall && (state == EISB_WRITE);
   assign pushData = '{first: firstByte, data: rxShift};

   always_ff @(posedge clk)
   begin
      if (!rst_n || startEv)
      begin
         firstByte <= 1'b1;
      end
      else if (pushReq && pushReady)
      begin
         firstByte <= 1'b0;
      end
   end

   eisb_fifo #(
      .WIDTH ($bits(eisb_rx_t)),
      .DEPTH (`EISB_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (pushReq),
      .inReady  (pushReady),
      .inData   (pushData),
      .outValid (rxValid),
      .outReady (rxReady),
      .outData  (rxData)
   );

   // ---------------------------------------------------------------
   // Status
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n || stopEv)
      begin
         status <= '0;
      end
      else if (startEv)
      begin
         status <= '{busy: 1'b1, selected: 1'b0, readMode: 1'b0, regSpace: 1'b0};
      end
      else if (ackSlotFall && (state == EISB_CTRL) && ctrlMatch)
      begin
         status.selected <= 1'b1;
         status.readMode <= rxShift[`EISB_DIR_BIT];
         status.regSpace <= rxShift[`EISB_PREFIX_SPACE];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         startPulse <= 1'b0;
         stopPulse  <= 1'b0;
      end
      else
      begin
         startPulse <= startEv;
         stopPulse  <= stopEv;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_START_BEGINS: assert property (@(posedge clk) disable iff (!rst_n)
      startEv |=> (state == EISB_CTRL) && status.busy && (bitCnt == 4'h0))
      else $error("START did not begin a transfer");

   AST_STOP_FREES: assert property (@(posedge clk) disable iff (!rst_n)
      stopEv |=> !status.busy && (state == EISB_IDLE) && sdaOeN)
      else $error("STOP did not free the bus");

   AST_BUSY_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
      (status.busy && !stopEv) |=> status.busy)
      else $error("Bus went free without STOP");

   AST_NEVER_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
      !sdaOeN |-> !sdaOut)
      else $error("Data line driven high");

   AST_IDLE_RELEASED: assert property (@(posedge clk) disable iff (!rst_n)
      ((state == EISB_IDLE) || (state == EISB_IGNORE)) ##1
      ((state == EISB_IDLE) || (state == EISB_IGNORE)) |-> sdaOeN)
      else $error("Data line held while idle or ignoring");

   AST_ACK_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
      (ackSlotFall && (state == EISB_CTRL) && decode_ctrl(rxShift, SEL_VALUE))
      |=> !sdaOeN && status.selected)
      else $error("Matched control byte not acknowledged");

   AST_NO_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
      (ackSlotFall && (state == EISB_CTRL) && !decode_ctrl(rxShift, SEL_VALUE))
      |=> (state == EISB_IGNORE) && sdaOeN && !status.selected)
      else $error("Unmatched control byte selected the device");

   AST_DIRECTION: assert property (@(posedge clk) disable iff (!rst_n)
      (ackSlotFall && (state == EISB_CTRL) && ctrlMatch)
      |=> status.readMode == $past(rxShift[0]))
      else $error("Direction bit not taken");

   AST_NINE_CLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
      (active && sclRise && (bitCnt == `EISB_BYTE_BITS) && !startEv && !stopEv)
      |=> bitCnt == `EISB_SLOT_END)
      else $error("Ack slot not the ninth clock");

   AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
      (active && sclRise && (bitCnt < `EISB_BYTE_BITS))
      |=> rxShift[0] == $past(sdaS) && rxShift[7:1] == $past(rxShift[6:0]))
      else $error("Bit not shifted in behind earlier bits");

   AST_MOVE_LOW_CLOCK: assert property (@(posedge clk) disable iff (!rst_n)
      ($changed(sdaOeN) && $past(status.busy) && !$past(startEv) && !$past(stopEv))
      |-> !$past(sclS))
      else $error("Data line moved while clock high");

endmodule

// [dv/eisb_master_model.sv]
// Behavioural two-wire bus master: makes the clock, START, STOP and bytes.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module eisb_master_model (
   // Clock
   input  wire logic clk,
   // Bus
   input  wire logic sda,
   output logic      scl,
   output logic      sdaLow
);
   // Lines move 1 ns after an edge; clock low 5 cycles, high 3 cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sdaLow = !b;
      tick(3);
      scl = 1'b1;
      repeat (3) @(posedge clk);
      r = sda;
      #1 scl = 1'b0;
   endtask

   // Release data under low clock, raise clock, then pull data low: START
   task automatic start_cond();
      tick(2);
      sdaLow = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b1;
      tick(3);
      scl = 1'b0;
   endtask

   // Pull data low under low clock, raise clock, then release data: STOP
   task automatic stop_cond();
      tick(2);
      sdaLow = 1'b1;
      tick(3);
      scl = 1'b1;
      tick(3);
      sdaLow = 1'b0;
      tick(3);
   endtask

   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   task automatic recv_byte(input logic ackIt, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(!ackIt, r);
   endtask

   // Idle bus: clock high, data released
   initial
   begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
endmodule

// [dv/tb.sv]
// Self-checking bench of the two-wire slave bit layer.
// Assumes the master model on the bus and a pull-up on the data wire.
`timescale 1ns/1ps
module tb;
   import eisb_pkg::*;

   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic         clk;
   logic         rst_n;
   logic         rxReady;
   logic         txValid;
   logic [7:0]   txData;
   logic         sdaOut;
   logic         sdaOeN;
   logic         rxValid;
   logic         txTaken;
   logic         startPulse;
   logic         stopPulse;
   logic         scl;
   logic         sdaLow;
   eisb_rx_t     rxData;
   eisb_status_t status;
   wire logic    sda;
   int           fails;
   int           samples_checked;
   int           nStart;
   int           nStop;
   logic [31:0]  rng;
   eisb_rx_t     expQ[$];
   logic [7:0]   txQ[$];
   logic         ack;
   logic [7:0]   rd;
   logic [7:0]   badCtrl[3] = '{8'hae, 8'hc0, 8'ha2};
   logic [7:0]   rdCtrl[2] = '{8'ha1, 8'hb1};

   // Wired-AND of both parties over a pull-up
   assign sda = !sdaLow && (sdaOeN || sdaOut);

   eisb_slave #(.SEL_VALUE(3'h0)) DUT (
      .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
      .txValid(txValid), .txData(txData), .txTaken(txTaken), .status(status),
      .startPulse(startPulse), .stopPulse(stopPulse));

   eisb_master_model master (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Expectations go in before the byte: the FIFO may hand it on mid-ack
   task automatic write_data(input int n, input int nAcked);
      logic       a;
      logic [7:0] v;
      for (int i = 0; i < n; i++)
      begin
         rng = xs(rng);
         v = rng[7:0];
         if (i < nAcked) expQ.push_back({i == 0, v});
         master.send_byte(v, a);
         check("dataAck", 9'(i < nAcked), 9'(a));
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Output watcher
   // ---------------------------------------------------------------
   always @(posedge clk)
   begin
      if (rxValid === 1'b1 && rxReady === 1'b1)
      begin
         if (expQ.size() == 0)
         begin
            fails++;
            $display("BAD rxData expected none seen %h", rxData);
         end
         else
            check("rxData", expQ.pop_front(), rxData);
      end
      if (sdaOeN === 1'b0)
         check("sdaOut", 9'h000, 9'(sdaOut));
      if (startPulse === 1'b1) nStart++;
      if (stopPulse === 1'b1) nStop++;
      if (txTaken === 1'b1)
      begin
         txQ.push_back(txData);
         rng = xs(rng);
         #1 txData = rng[7:0];
      end
   end

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Whole run is near 200 us of bus traffic
   initial
   begin
      #3000000;
      fails++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      rxReady = 1'b1;
      txValid = 1'b0;
      txData = 8'h00;
      rng = 32'd37;
      wait_cyc(3);
      rst_n = 1'b1;
      wait_cyc(4);
      check("idleOe", 9'h001, 9'(sdaOeN));

      master.start_cond();
      master.send_byte(8'ha0, ack);
      check("ctrlAck", 9'h001, 9'(ack));
      check("status", 9'h00c, 9'(status));
      write_data(3, 3);
      master.stop_cond();
      wait_cyc(6);
      check("statusEnd", 9'h000, 9'(status));
      $display("test write finished");

      for (int i = 0; i < 3; i++)
      begin
         master.start_cond();
         master.send_byte(badCtrl[i], ack);
         check("badAck", 9'h000, 9'(ack));
         write_data(1, 0);
         master.stop_cond();
      end
      $display("test unselected finished");

      txValid = 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         master.start_cond();
         master.send_byte(rdCtrl[i], ack);
         check("rdAck", 9'h001, 9'(ack));
         check("rdStatus", 9'(4'he | 4'(i)), 9'(status));
         master.recv_byte(1'b1, rd);
         check("rdByte", 9'(txQ.pop_front()), 9'(rd));
         master.recv_byte(1'b0, rd);
         check("rdByte", 9'(txQ.pop_front()), 9'(rd));
         master.stop_cond();
      end
      txValid = 1'b0;
      $display("test read finished");

      master.start_cond();
      master.send_byte(8'ha0, ack);
      for (int i = 0; i < 4; i++) master.bit_io(1'b1, ack);
      master.start_cond();
      master.send_byte(8'ha0, ack);
      check("restartAck", 9'h001, 9'(ack));
      write_data(1, 1);
      master.stop_cond();
      $display("test restart finished");

      rxReady = 1'b0;
      master.start_cond();
      master.send_byte(8'ha0, ack);
      write_data(5, 4);
      master.stop_cond();
      rxReady = 1'b1;
      wait_cyc(10);
      check("drained", 9'h000, 9'(expQ.size()));
      check("rxValid", 9'h000, 9'(rxValid));
      $display("test fifo finished");

      check("starts", 9'd9, 9'(nStart));
      check("stops", 9'd8, 9'(nStop));
      stop_test();
   end
endmodule
